// *** inc/sra_pkg.sv ***
////////////////////////////////////////////////////////////////////////////////
// shared constants and types for the serial register access host
`default_nettype none

package sra_pkg;

  // system clock and bus timing
  localparam int CLK_MHZ = 250;
  localparam int SCL_PERIOD_NS = 1000;
  // quarter of the serial clock period, rounded up so the bus never runs fast
  localparam int QTR_CYC_I = (SCL_PERIOD_NS * CLK_MHZ + 4 * 1000 - 1) / (4 * 1000);
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] QTR_CYC = CNT_W'(QTR_CYC_I);

  // address bytes including the direction bit
  localparam logic [7:0] SLV_ADDR_WR = 8'hD6;
  localparam logic [7:0] SLV_ADDR_RD = 8'hD7;

  // bit position of the acknowledge slot inside a byte
  localparam logic [3:0] BIT_ACK = 4'h8;

  // quarter phases of one serial clock period
  localparam logic [1:0] PH_LOW0 = 2'h0;
  localparam logic [1:0] PH_LOW1 = 2'h1;
  localparam logic [1:0] PH_HIGH0 = 2'h2;
  localparam logic [1:0] PH_HIGH1 = 2'h3;

  // level driven on the fixed-configuration select pin
  localparam logic CFG_SEL_LVL = 1'h0;

  // reset values
  localparam logic [8:0] REM_RST = 9'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // main sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_TXB = 3'b010,
    ST_FETCH = 3'b011,
    ST_RXB = 3'b100,
    ST_PUSH = 3'b101,
    ST_STOP = 3'b110
  } sra_state_t;

  // which byte of the transaction is on the wire
  typedef enum logic [2:0] {
    SQ_ADDRW = 3'b000,
    SQ_REG = 3'b001,
    SQ_DATA = 3'b010,
    SQ_ADDRR = 3'b011,
    SQ_RDATA = 3'b100
  } sra_seq_t;

endpackage : sra_pkg

`default_nettype wire

// *** core/sra_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// two-stage synchroniser per bit, resets to the idle-high bus level
module sra_sync #(
  parameter int W = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      // first stage feeds only the second
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          meta_q <= 1'h1;
          sync_q <= 1'h1;
        end
        else if (ce)
        begin
          meta_q <= d[i];
          sync_q <= meta_q;
        end
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule : sra_sync

`default_nettype wire

// *** core/sra_buf2.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// two-entry buffer with valid and ready on both sides
module sra_buf2 #(
  parameter int W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rp_q];

  // storage, written only on push
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else if (ce && push)
    begin
      mem_q[wp_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wp_q <= 1'h0;
      rp_q <= 1'h0;
      cnt_q <= 2'h0;
    end
    else if (ce)
    begin
      if (push)
        wp_q <= ~wp_q;
      if (pop)
        rp_q <= ~rp_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end

endmodule : sra_buf2

`default_nettype wire

// *** core/sra_host.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// bus master that reads and writes the receiver's registers
module sra_host
  import sra_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_len,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic busy,
  output logic done,
  output logic nack_err,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic cfg_sel_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  sra_state_t st_q;
  sra_seq_t seq_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] reg_q;
  logic [8:0] rem_q;
  logic rd_q;
  logic rs_q;
  logic err_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic done_q;
  logic nack_q;
  logic scl_s;
  logic sda_s;
  logic bus_st;
  logic adv;
  logic tick;
  logic fin;
  logic rx_ack;
  logic buf_in_ready;
  logic buf_in_valid;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs through two flip-flops

  sra_sync #(
    .W(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data buffer, stalls the sequencer when full

  assign buf_in_valid = (st_q == ST_PUSH);

  sra_buf2 #(
    .W(8)
  ) u_buf (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(sh_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // handshake and status outputs

  assign cmd_ready = (st_q == ST_IDLE);
  assign wr_ready = (st_q == ST_FETCH);
  assign busy = (st_q != ST_IDLE);
  assign done = done_q;
  assign nack_err = nack_q;
  // open-drain: only ever pull low
  assign scl_o = 1'h0;
  assign sda_o = 1'h0;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign cfg_sel_o = CFG_SEL_LVL;

  ////////////////////////////////////////////////////////////////////////////
  // quarter-period timing

  // states timed by the quarter phases; a non-repeated start leaves the clock released
  assign bus_st = (st_q == ST_START) || (st_q == ST_TXB) ||
                  (st_q == ST_RXB) || (st_q == ST_STOP);
  // high phase waits for the clock to really be high; start also for a free bus
  assign adv = (ph_q != PH_HIGH0) ||
               (scl_s && ((st_q != ST_START) || sda_s));
  assign tick = bus_st && (cnt_q == '0) && adv;
  assign fin = tick && (ph_q == PH_HIGH1);
  // acknowledge every read byte but the last
  assign rx_ack = (rem_q > 9'h001);

  // quarter counter and phase, held while the clock is stretched
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cnt_q <= QTR_CYC;
      ph_q <= PH_LOW0;
    end
    else if (ce)
    begin
      if (!bus_st)
      begin
        cnt_q <= QTR_CYC;
        ph_q <= PH_LOW0;
      end
      else if (cnt_q != '0)
        cnt_q <= cnt_q - CNT_W'(1);
      else if (adv)
      begin
        cnt_q <= QTR_CYC;
        ph_q <= ph_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction sequencer

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_q <= ST_IDLE;
      seq_q <= SQ_ADDRW;
      bit_q <= 4'h0;
      sh_q <= BYTE_RST;
      reg_q <= BYTE_RST;
      rem_q <= REM_RST;
      rd_q <= 1'h0;
      rs_q <= 1'h0;
      err_q <= 1'h0;
    end
    else if (ce)
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (cmd_valid)
          begin
            st_q <= ST_START;
            seq_q <= SQ_ADDRW;
            sh_q <= SLV_ADDR_WR;
            reg_q <= cmd_reg;
            rem_q <= {1'h0, cmd_len} + 9'h001;
            rd_q <= cmd_read;
            rs_q <= 1'h0;
            err_q <= 1'h0;
          end
        end
        ST_START:
        begin
          if (fin)
          begin
            st_q <= ST_TXB;
            bit_q <= 4'h0;
          end
        end
        ST_TXB:
        begin
          if (fin)
          begin
            if (bit_q != BIT_ACK)
            begin
              bit_q <= bit_q + 4'h1;
              sh_q <= {sh_q[6:0], 1'h0};
            end
            else if (sda_s)
            begin
              // missing acknowledge: give up and close the bus
              err_q <= 1'h1;
              st_q <= ST_STOP;
            end
            else
            begin
              case (seq_q)
                SQ_ADDRW:
                begin
                  seq_q <= SQ_REG;
                  sh_q <= reg_q;
                  bit_q <= 4'h0;
                end
                SQ_REG:
                begin
                  if (rd_q)
                  begin
                    seq_q <= SQ_ADDRR;
                    sh_q <= SLV_ADDR_RD;
                    rs_q <= 1'h1;
                    st_q <= ST_START;
                  end
                  else
                  begin
                    seq_q <= SQ_DATA;
                    st_q <= ST_FETCH;
                  end
                end
                SQ_DATA:
                begin
                  // burst continues until the count is used, then stop
                  rem_q <= rem_q - 9'h001;
                  st_q <= (rem_q == 9'h001) ? ST_STOP : ST_FETCH;
                end
                SQ_ADDRR:
                begin
                  seq_q <= SQ_RDATA;
                  st_q <= ST_RXB;
                  bit_q <= 4'h0;
                end
                default:
                begin
                  st_q <= ST_STOP;
                end
              endcase
            end
          end
        end
        ST_FETCH:
        begin
          if (wr_valid)
          begin
            sh_q <= wr_data;
            bit_q <= 4'h0;
            st_q <= ST_TXB;
          end
        end
        ST_RXB:
        begin
          if (fin)
          begin
            if (bit_q != BIT_ACK)
            begin
              // sample in the high phase, msb arrives first
              sh_q <= {sh_q[6:0], sda_s};
              bit_q <= bit_q + 4'h1;
            end
            else
              st_q <= ST_PUSH;
          end
        end
        ST_PUSH:
        begin
          if (buf_in_ready)
          begin
            rem_q <= rem_q - 9'h001;
            // after the nack the read is still closed by a stop
            st_q <= (rem_q == 9'h001) ? ST_STOP : ST_RXB;
            bit_q <= 4'h0;
          end
        end
        ST_STOP:
        begin
          if (fin)
            st_q <= ST_IDLE;
        end
        default:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock line drive: low in the first half of each period, released throughout a non-repeated start

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      scl_oe_q <= 1'h0;
    else if (ce)
    begin
      case (st_q)
        ST_IDLE: scl_oe_q <= 1'h0;
        ST_START: scl_oe_q <= rs_q && (ph_q != PH_HIGH0) && (ph_q != PH_HIGH1);
        ST_TXB, ST_RXB, ST_STOP: scl_oe_q <= (ph_q == PH_LOW0) || (ph_q == PH_LOW1);
        default: scl_oe_q <= scl_oe_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data line drive: changes only with the clock low, except start and stop

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      sda_oe_q <= 1'h0;
    else if (ce)
    begin
      case (st_q)
        ST_IDLE: sda_oe_q <= 1'h0;
        ST_START: sda_oe_q <= (ph_q == PH_HIGH1);
        ST_TXB:
        begin
          if (ph_q == PH_LOW1)
            sda_oe_q <= (bit_q != BIT_ACK) && !sh_q[7];
        end
        ST_RXB:
        begin
          if (ph_q == PH_LOW1)
            sda_oe_q <= (bit_q == BIT_ACK) && rx_ack;
        end
        ST_STOP:
        begin
          if (ph_q != PH_LOW0)
            sda_oe_q <= (ph_q != PH_HIGH1);
        end
        default: sda_oe_q <= sda_oe_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion pulses at the end of the stop condition

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      done_q <= 1'h0;
      nack_q <= 1'h0;
    end
    else if (ce)
    begin
      done_q <= (st_q == ST_STOP) && fin;
      nack_q <= (st_q == ST_STOP) && fin && err_q;
    end
  end

endmodule : sra_host

`default_nettype wire

// *** verif/sra_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// protocol checker on the host ports
module sra_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic busy,
  input wire logic done,
  input wire logic nack_err,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic cfg_sel_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // start edge, then clock held low for a bounded time
  sequence s_start; $rose(sda_oe) && !scl_oe; endsequence
  sequence s_stop; $fell(sda_oe) && !scl_oe; endsequence
  sequence s_low; scl_oe [*8] ##[1:300] !scl_oe; endsequence
  property p_cfg; cfg_sel_o == 1'b0; endproperty
  property p_od; !scl_o && !sda_o; endproperty
  property p_take; cmd_valid && cmd_ready |=> busy ##[0:400] (sda_oe && !scl_oe); endproperty
  property p_refuse; busy |-> !cmd_ready; endproperty
  property p_start; s_start |=> sda_oe throughout (##[1:300] scl_oe); endproperty
  property p_low; $rose(scl_oe) |-> s_low; endproperty
  property p_stop; s_stop |-> (!sda_oe && !scl_oe) throughout (##[1:300] done); endproperty
  property p_done; done |=> !done; endproperty
  property p_nack; nack_err |-> done; endproperty
  a_cfg: assert property (p_cfg) else $error("select pin not low");
  a_od: assert property (p_od) else $error("line driven high");
  a_take: assert property (p_take) else $error("no start after command");
  a_refuse: assert property (p_refuse) else $error("ready while busy");
  a_start: assert property (p_start) else $error("start not framed");
  a_low: assert property (p_low) else $error("clock low phase wrong");
  a_stop: assert property (p_stop) else $error("stop not followed by done");
  a_done: assert property (p_done) else $error("done too long");
  a_nack: assert property (p_nack) else $error("nack without done");
endmodule : sra_chk

bind sra_host sra_chk u_chk (.clk_sys, .reset, .cmd_valid, .cmd_ready, .busy, .done,
  .nack_err, .scl_oe, .sda_oe, .scl_o, .sda_o, .cfg_sel_o);

`default_nettype wire

// *** verif/sra_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// register device on the two-wire bus
module sra_dev_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic sel,
  input wire logic nak,
  input wire logic slow,
  output logic scl_pull,
  output logic sda_pull
);
  logic [7:0] mem [256];
  logic [7:0] sh, tx, ptr;
  logic act, rdp, mack;
  int bc, bn;
  initial begin act = 0; scl_pull = 0; sda_pull = 0; end
  // start or repeated start rearms the byte count; the first clock fall after it carries no bit
  always @(negedge sda) if (scl) begin act = 1; bc = -1; bn = 0; rdp = 0; sda_pull = 0; end
  // stop returns to idle
  always @(posedge sda) if (scl) begin act = 0; sda_pull = 0; end
  // sample on the rising clock
  always @(posedge scl) if (act) begin if (bc < 8) sh = {sh[6:0], sda}; else mack = !sda; end
  // optional clock stretch for a slow answer, outlasting the host's own low half and first high quarter
  always @(negedge scl) if (slow) begin scl_pull = 1; #1000 scl_pull = 0; end
  // shift, acknowledge and advance on the falling clock
  always @(negedge scl) if (act) begin
    if (bc == 7 && !(rdp && bn > 0)) begin
      bc = 8;
      if (bn == 0) begin
        rdp = sh[0];
        if (sh[7:1] != 7'h6B || sel || nak) act = 0;
        else sda_pull = 1;
      end else begin
        if (bn == 1) ptr = sh;
        else begin mem[ptr] = sh; ptr = ptr + 8'h01; end
        sda_pull = 1;
      end
      bn++;
    end else if (bc == 7) begin bc = 8; sda_pull = 0; end
    else if (bc == 8) begin
      bc = 0;
      sda_pull = 0;
      if (rdp && (bn == 1 || mack)) begin bn = 2; tx = mem[ptr]; ptr = ptr + 8'h01; sda_pull = !tx[7]; end
      else if (rdp) act = 0;
    end else begin bc++; if (rdp && bn > 0) sda_pull = !tx[7-bc]; end
  end
endmodule : sra_dev_model

`default_nettype wire

// *** verif/sra_host_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the host
module sra_host_tb;
  import sra_pkg::*;
  logic clk_sys = 0, reset = 1, ce = 1, cmd_valid = 0, cmd_read = 0, wr_valid = 0, rd_ready = 0;
  logic [7:0] cmd_reg = 8'h00, cmd_len = 8'h00, wr_data = 8'h00, rd_data;
  logic nak = 0, slow = 0, cmd_ready, wr_ready, rd_valid, busy, done, nack_err;
  logic scl_o, scl_oe, sda_o, sda_oe, cfg_sel_o, scl_pull, sda_pull, scl_i, sda_i;
  logic [7:0] q[$], xq[$];
  int n_mismatch = 0, comparisons = 0;
  // pulled-up wires
  assign scl_i = !(scl_oe || scl_pull);
  assign sda_i = !(sda_oe || sda_pull);
  always #2 clk_sys = !clk_sys;
  sra_host uut (.clk_sys, .reset, .ce, .cmd_valid, .cmd_ready, .cmd_read, .cmd_reg, .cmd_len,
    .wr_valid, .wr_ready, .wr_data, .rd_valid, .rd_ready, .rd_data, .busy, .done, .nack_err,
    .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .cfg_sel_o);
  sra_dev_model dev (.scl(scl_i), .sda(sda_i), .sel(cfg_sel_o), .nak, .slow, .scl_pull, .sda_pull);

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, s); end
  endtask : chk

  // one transaction, serving both data streams until done
  task automatic run(input logic rd, input logic [7:0] rg, input logic [7:0] ln, input logic en, input int stall);
    int i;
    cmd_read <= rd;
    cmd_reg <= rg;
    cmd_len <= ln;
    cmd_valid <= 1;
    for (i = 0; i < 60000; i++) begin
      @(posedge clk_sys);
      if (cmd_valid && cmd_ready) cmd_valid <= 0;
      if (wr_valid && wr_ready) void'(q.pop_front());
      if (rd_valid && rd_ready) chk("rd_data", xq.size() != 0 ? xq.pop_front() : 8'h00, rd_data);
      // leave before driving, so the closing release is the only drive in this step
      if (done) break;
      wr_valid <= !rd && q.size() != 0;
      wr_data <= q.size() != 0 ? q[0] : 8'h00;
      rd_ready <= i >= stall;
    end
    if (i == 60000) begin n_mismatch++; $display("BAD done exp 1 got 0"); finish_test(); end
    chk("nack_err", {7'h00, en}, {7'h00, nack_err});
    chk("rd_left", 8'h00, 8'(xq.size()));
    q.delete();
    wr_valid <= 0;
    rd_ready <= 0;
  endtask : run

  task automatic t_write;
    q = '{8'hA5, 8'h3C, 8'hF0};
    run(0, 8'h10, 8'h02, 0, 0);
    chk("reg10", 8'hA5, dev.mem[8'h10]);
    chk("reg11", 8'h3C, dev.mem[8'h11]);
    chk("reg12", 8'hF0, dev.mem[8'h12]);
    chk("cfg_sel", 8'h00, {7'h00, cfg_sel_o});
    $display("burst write finished");
  endtask : t_write

  task automatic t_read;
    slow = 1;
    xq = '{8'hA5, 8'h3C, 8'hF0};
    run(1, 8'h10, 8'h02, 0, 22000);
    slow = 0;
    $display("stalled slow read finished");
  endtask : t_read

  task automatic t_nack;
    nak = 1;
    q = '{8'h5A};
    run(0, 8'h10, 8'h00, 1, 0);
    nak = 0;
    chk("reg10_kept", 8'hA5, dev.mem[8'h10]);
    $display("refused address finished");
  endtask : t_nack

  task automatic t_edge;
    q = '{8'hC3};
    run(0, 8'hFF, 8'h00, 0, 0);
    chk("regff", 8'hC3, dev.mem[8'hFF]);
    xq = '{8'hC3};
    run(1, 8'hFF, 8'h00, 0, 0);
    $display("single byte back to back finished");
  endtask : t_edge

  // reset, then the scenarios
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    t_write();
    t_read();
    t_nack();
    t_edge();
    finish_test();
  end
endmodule : sra_host_tb

`default_nettype wire
